// >>> testbench/rfp_fault_protect_props.sv
// Port-level assertions for the fault-protection block
`timescale 1ns/100ps
`default_nettype none
module rfp_fault_props #(
   parameter integer SS_DELAY_CYC = 30
) (
   input wire logic SYS_CLK,
   input wire logic RST_N,
   input wire logic REGULATOR_ENABLE_PIN,
   input wire logic OC_SHORT,
   input wire logic SEVERE_OV_HIGH,
   input wire logic HS_GATE_LOW,
   input wire logic LS_GATE_LOW,
   input wire logic OUT_NEAR_SETPOINT,
   input wire logic REG_RD,
   input wire logic [7:0] REG_RDATA,
   input wire logic HIGH_SIDE_DRIVE,
   input wire logic LOW_SIDE_DRIVE,
   input wire logic POWER_GOOD_OUTPUT_OE,
   input wire logic STARTUP_SLEW_SEL,
   input wire logic DYNAMIC_SLEW_CURRENT_SEL
);
   reg [8:0] sh_cnt_q;
   // Run length of a hard short while enabled; 400 cycles is the 2 us limit
   always @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N)
         sh_cnt_q <= 9'h000;
      else if (!OC_SHORT || !REGULATOR_ENABLE_PIN)
         sh_cnt_q <= 9'h000;
      else if (sh_cnt_q != 9'h190)
         sh_cnt_q <= sh_cnt_q + 9'h001;
   end
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);
   // Gate interlock, power-down behaviour and startup order
   hs_interlock_a: assert property ($rose(HIGH_SIDE_DRIVE) |-> !LOW_SIDE_DRIVE && $past(LS_GATE_LOW))
      else $error("high side rose with low gate up");
   ls_interlock_a: assert property ($rose(LOW_SIDE_DRIVE) |-> !HIGH_SIDE_DRIVE && $past(HS_GATE_LOW))
      else $error("low side rose with high gate up");
   severe_hold_a: assert property (SEVERE_OV_HIGH [*8] |-> !HIGH_SIDE_DRIVE && POWER_GOOD_OUTPUT_OE)
      else $error("severe overvoltage left high side on");
   short_trip_a: assert property (sh_cnt_q == 9'h190 |->
      !HIGH_SIDE_DRIVE && !LOW_SIDE_DRIVE && POWER_GOOD_OUTPUT_OE)
      else $error("hard short not tripped in time");
   pg_release_a: assert property ($fell(POWER_GOOD_OUTPUT_OE) |->
      $past(OUT_NEAR_SETPOINT, 8) && REGULATOR_ENABLE_PIN)
      else $error("power good released early");
   rd_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
      else $error("read data outside read answer");
   slew_excl_a: assert property (!(STARTUP_SLEW_SEL && DYNAMIC_SLEW_CURRENT_SEL))
      else $error("both slew sources selected");
   en_off_a: assert property (!REGULATOR_ENABLE_PIN [*8] |->
      !HIGH_SIDE_DRIVE && POWER_GOOD_OUTPUT_OE && !STARTUP_SLEW_SEL)
      else $error("active while disabled");
   ss_delay_a: assert property ($rose(STARTUP_SLEW_SEL) |-> $past(REGULATOR_ENABLE_PIN, SS_DELAY_CYC))
      else $error("soft start began too soon");
   hs_on_c: cover property ($rose(HIGH_SIDE_DRIVE));
   pg_rel_c: cover property ($fell(POWER_GOOD_OUTPUT_OE));
   short_c: cover property (sh_cnt_q == 9'h190);
endmodule
bind rfp_fault_protect rfp_fault_props #(.SS_DELAY_CYC(SS_DELAY_CYC)) props_u (
   .SYS_CLK(SYS_CLK), .RST_N(RST_N), .REGULATOR_ENABLE_PIN(REGULATOR_ENABLE_PIN),
   .OC_SHORT(OC_SHORT), .SEVERE_OV_HIGH(SEVERE_OV_HIGH), .HS_GATE_LOW(HS_GATE_LOW),
   .LS_GATE_LOW(LS_GATE_LOW), .OUT_NEAR_SETPOINT(OUT_NEAR_SETPOINT), .REG_RD(REG_RD),
   .REG_RDATA(REG_RDATA), .HIGH_SIDE_DRIVE(HIGH_SIDE_DRIVE), .LOW_SIDE_DRIVE(LOW_SIDE_DRIVE),
   .POWER_GOOD_OUTPUT_OE(POWER_GOOD_OUTPUT_OE), .STARTUP_SLEW_SEL(STARTUP_SLEW_SEL),
   .DYNAMIC_SLEW_CURRENT_SEL(DYNAMIC_SLEW_CURRENT_SEL));
`default_nettype wire

// >>> testbench/rfp_fet_model.sv
// Power stage model reporting when each gate has discharged
`timescale 1ns/100ps
`default_nettype none
module rfp_fet_model (
   input wire logic clk,
   input wire logic hs_drv,
   input wire logic ls_drv,
   output wire logic hs_low,
   output wire logic ls_low
);
   logic [2:0] hs_q = 3'h0;
   logic [2:0] ls_q = 3'h0;
   // Gates charge at once but take three cycles to fall below the turn-on level
   always @(posedge clk) begin
      hs_q <= {hs_q[1:0], hs_drv};
      ls_q <= {ls_q[1:0], ls_drv};
   end
   assign hs_low = ~|{hs_q, hs_drv};
   assign ls_low = ~|{ls_q, ls_drv};
endmodule
`default_nettype wire

// >>> testbench/rfp_tb.sv
// Self-checking bench for the fault-protection block
`include "rfp_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module tb;
   reg clk = 1'b0, rst_n = 1'b0, en = 1'b0, oc = 1'b0, sov_hi = 1'b0, sov_lo = 1'b0;
   reg near = 1'b0, sdone = 1'b0, swc = 1'b0, hreq = 1'b0, lreq = 1'b0, wr = 1'b0, rd = 1'b0;
   reg [2:0] src = 3'h0;
   reg [3:0] addr = 4'h0;
   reg [7:0] wdata = 8'h00;
   reg [7:0] v;
   reg ia;
   wire [7:0] rdata;
   wire irq, hs, ls, pgo, pgoe, ss_sel, dv_sel, chg, hgl, lgl;
   integer error_cnt = 0, tests_run = 0, i;
   rfp_fault_protect #(.OC_SAMPLE_CYC(20), .UVOV_CYC(50), .SS_DELAY_CYC(30)) dut_u (
      .SYS_CLK(clk), .RST_N(rst_n), .REGULATOR_ENABLE_PIN(en), .OC_OVER(oc),
      .OC_SHORT(src[2]), .UV_BELOW_SLEW(src[0]), .OV_ABOVE_SLEW(src[1]),
      .SEVERE_OV_HIGH(sov_hi), .SEVERE_OV_LOW(sov_lo), .HS_GATE_LOW(hgl), .LS_GATE_LOW(lgl),
      .OUT_NEAR_SETPOINT(near), .SOFT_DONE(sdone), .SW_CYCLE(swc), .PWM_HS_REQ(hreq),
      .PWM_LS_REQ(lreq), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
      .REG_RDATA(rdata), .IRQ(irq), .HIGH_SIDE_DRIVE(hs), .LOW_SIDE_DRIVE(ls),
      .POWER_GOOD_OUTPUT_O(pgo), .POWER_GOOD_OUTPUT_OE(pgoe), .STARTUP_SLEW_SEL(ss_sel),
      .DYNAMIC_SLEW_CURRENT_SEL(dv_sel), .SLEW_CHARGE_ENABLE(chg));
   rfp_fet_model fet_u (.clk(clk), .hs_drv(hs), .ls_drv(ls), .hs_low(hgl), .ls_low(lgl));
   initial begin
      forever #2.5 clk = ~clk;
   end
   task chk(input string nm, input [7:0] seen, input [7:0] exp);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("unexpected %0s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task cyc(input integer n);
      begin
         repeat (n) @(posedge clk);
         #1;
      end
   endtask
   task wreg(input [3:0] a, input [7:0] d);
      begin
         @(posedge clk);
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
         @(posedge clk);
         wr <= 1'b0;
      end
   endtask
   // Data stands only in the cycle after the strobe, so sample just past that edge
   task rreg(input [3:0] a, output [7:0] d);
      begin
         @(posedge clk);
         addr <= a;
         rd <= 1'b1;
         @(posedge clk);
         rd <= 1'b0;
         #1;
         d = rdata;
      end
   endtask
   task swp(input integer n);
      begin
         repeat (n) begin
            @(posedge clk);
            swc <= 1'b1;
            repeat (3) @(posedge clk);
            swc <= 1'b0;
            repeat (3) @(posedge clk);
         end
      end
   endtask
   task start_up;
      begin
         @(posedge clk);
         en <= 1'b1;
         cyc(20);
         chk("early soft start", ss_sel, 0);
         chk("no charge before ramp", chg, 0);
         cyc(30);
         chk("startup source", {ss_sel, dv_sel}, 2);
         chk("slew charge on", chg, 1);
         @(posedge clk);
         sdone <= 1'b1;
         near <= 1'b1;
         cyc(8);
         chk("dynamic source", {ss_sel, dv_sel}, 1);
         swp(12);
         cyc(6);
         chk("power good held", pgoe, 1);
         swp(1);
         cyc(6);
         chk("power good free", pgoe, 0);
         chk("power good pin level", pgo, 0);
         $display("startup test done");
      end
   endtask
   // Dropping enable is the only clear short of a supply reset
   task en_cycle;
      begin
         @(posedge clk);
         en <= 1'b0;
         sdone <= 1'b0;
         near <= 1'b0;
         cyc(10);
      end
   endtask
   task conclude;
      begin
         $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
         if (error_cnt == 0 && tests_run > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   initial begin
      #100000;
      error_cnt = error_cnt + 1;
      conclude;
   end
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rreg(`RFP_ADDR_MASK, v);
      chk("mask reset", v, 8'h00);
      rreg(`RFP_ADDR_CTRL, v);
      chk("ctrl reset", v, 8'h01);
      rreg(4'hf, v);
      chk("unmapped read", v, 8'h00);
      chk("power good at reset", pgoe, 1);
      $display("register test done");
      start_up;
      // Hand the bridge back and forth through the interlock
      @(posedge clk);
      hreq <= 1'b1;
      cyc(12);
      chk("high side on", {hs, ls}, 2);
      @(posedge clk);
      hreq <= 1'b0;
      lreq <= 1'b1;
      cyc(12);
      chk("low side on", {hs, ls}, 1);
      @(posedge clk);
      lreq <= 1'b0;
      hreq <= 1'b1;
      oc <= 1'b1;
      cyc(100);
      rreg(`RFP_ADDR_STATE, v);
      chk("no early trip", v[1], 0);
      chk("counter running", |v[7:5], 1);
      // Ten under-samples walk the count down and must leave it pinned at zero
      @(posedge clk);
      oc <= 1'b0;
      cyc(200);
      rreg(`RFP_ADDR_STATE, v);
      chk("counter floor", v[7:5], 0);
      @(posedge clk);
      oc <= 1'b1;
      cyc(200);
      rreg(`RFP_ADDR_STATE, v);
      chk("overcurrent trip", v[1], 1);
      chk("fault drives", {hs, ls, pgoe}, 1);
      rreg(`RFP_ADDR_STATUS, v);
      chk("oc status", v[0], 1);
      wreg(`RFP_ADDR_MASK, 8'h00);
      cyc(1);
      ia = irq;
      wreg(`RFP_ADDR_MASK, 8'h3f);
      cyc(1);
      chk("mask effect", ia ^ irq, 1);
      wreg(`RFP_ADDR_MASK, ia ? 8'h00 : 8'h3f);
      wreg(`RFP_ADDR_CTRL, 8'h00);
      cyc(1);
      chk("irq disabled", irq, 0);
      wreg(`RFP_ADDR_CTRL, 8'h01);
      @(posedge clk);
      oc <= 1'b0;
      en_cycle;
      wreg(`RFP_ADDR_STATUS, 8'h3f);
      rreg(`RFP_ADDR_STATUS, v);
      chk("status cleared", v, 8'h00);
      chk("irq cleared", irq, 0);
      rreg(`RFP_ADDR_STATE, v);
      chk("faults cleared", v & 8'hfe, 8'h00);
      $display("overcurrent test done");
      start_up;
      // Undervoltage, overvoltage, then hard short
      for (i = 0; i < 3; i = i + 1) begin
         @(posedge clk);
         src <= 3'h1 << i;
         cyc(20);
         rreg(`RFP_ADDR_STATE, v);
         chk("no quick trip", v & 8'h0e, 8'h00);
         cyc(400);
         rreg(`RFP_ADDR_STATE, v);
         chk("comparator trip", v & 8'h0e, i == 2 ? 8'h02 : 8'h04 << i);
         chk("fault drives", {hs, ls, pgoe}, 1);
         @(posedge clk);
         src <= 3'h0;
         cyc(20);
         rreg(`RFP_ADDR_STATE, v);
         chk("fault latched", v & 8'h0e, i == 2 ? 8'h02 : 8'h04 << i);
         en_cycle;
         start_up;
      end
      $display("comparator test done");
      // Severe overvoltage on top of a latched undervoltage
      @(posedge clk);
      src <= 3'h1;
      cyc(80);
      @(posedge clk);
      sov_hi <= 1'b1;
      src <= 3'h0;
      cyc(14);
      chk("severe drives", {hs, ls, pgoe}, 3);
      rreg(`RFP_ADDR_STATE, v);
      chk("severe flag", v[4], 1);
      @(posedge clk);
      sov_hi <= 1'b0;
      sov_lo <= 1'b1;
      cyc(12);
      chk("low side off", ls, 0);
      @(posedge clk);
      sov_lo <= 1'b0;
      sov_hi <= 1'b1;
      cyc(14);
      chk("low side again", ls, 1);
      @(posedge clk);
      sov_hi <= 1'b0;
      en_cycle;
      rreg(`RFP_ADDR_STATE, v);
      chk("severe kept", v[4], 1);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      cyc(4);
      rreg(`RFP_ADDR_STATE, v);
      chk("severe cleared", v[4], 0);
      $display("severe test done");
      conclude;
   end
endmodule
`default_nettype wire

// >>> verilog/rfp_consts.vh
// Constants for the regulator fault-protection block
`ifndef RFP_CONSTS_VH
`define RFP_CONSTS_VH
`define RFP_CLK_MHZ 200
`define RFP_OC_SAMPLE_NS 15000
`define RFP_OC_SAMPLE_CYC (`RFP_OC_SAMPLE_NS * `RFP_CLK_MHZ / 1000)
`define RFP_OC_TRIP_COUNT 8
`define RFP_SHORT_NS 2000
`define RFP_SHORT_CYC (`RFP_SHORT_NS * `RFP_CLK_MHZ / 1000)
`define RFP_UVOV_NS 1000000
`define RFP_UVOV_CYC (`RFP_UVOV_NS * `RFP_CLK_MHZ / 1000)
`define RFP_SS_DELAY_NS 100000
`define RFP_SS_DELAY_CYC (`RFP_SS_DELAY_NS * `RFP_CLK_MHZ / 1000)
`define RFP_PG_SW_CYCLES 13
`define RFP_ADDR_STATUS 4'h0
`define RFP_ADDR_MASK 4'h1
`define RFP_ADDR_STATE 4'h2
`define RFP_ADDR_CTRL 4'h3
`define RFP_BIT_OC 0
`define RFP_BIT_SHORT 1
`define RFP_BIT_UV 2
`define RFP_BIT_OV 3
`define RFP_BIT_SOV 4
`define RFP_BIT_PG 5
`define RFP_EVT_W 6
`define RFP_MASK_RST 6'h00
`define RFP_CTRL_RST 1'h1
`endif

// >>> verilog/rfp_fault_protect.v
// Fault protection, startup sequencing and slew-source selection for a buck controller
// Summary of operation
// RULE1 - Every 15 us the overcurrent comparator is sampled; the counter counts up when over, down when under.
// RULE2 - An overcurrent fault latches when that counter reaches eight.
// RULE3 - A hard short (over 2.5x threshold) latches an overcurrent fault within 2 us, bypassing the counter.
// RULE4 - Output more than 300 mV below the slew node for over 1 ms latches an undervoltage fault.
// RULE5 - Output more than 195 mV above the slew node for over 1 ms latches an overvoltage fault.
// RULE6 - Under/overvoltage compare against the present slew node, ramping or static.
// RULE7 - A latched fault pulls power good low and both gate drives low.
// RULE8 - Latched faults persist until the enable pin falls or the supply reset occurs.
// RULE9 - Output above 1.545 V raises severe overvoltage at once, holding high side and power good low.
// RULE10 - In severe overvoltage the low side is high until output falls below 0.77 V, toggling thereafter.
// RULE11 - Severe overvoltage can assert over other faults and only a supply reset clears it.
// RULE12 - Neither gate drive goes high until the opposite gate has fallen below about 1 V.
// RULE13 - During soft-start only the one-way startup slew source is connected.
// RULE14 - After soft-start the two-way dynamic slew source is connected.
// RULE15 - About 100 us after enable with supply good, the soft-start ramp begins.
// RULE16 - Within ten percent of set-point, 13 switching cycles pass before power good is released.
// RULE17 - The overcurrent counter saturates at zero and clears when the fault latches reset.
`include "rfp_consts.vh"
`timescale 1ns/100ps
`default_nettype none
module rfp_fault_protect #(
   parameter integer OC_SAMPLE_CYC = `RFP_OC_SAMPLE_CYC,
   parameter integer UVOV_CYC = `RFP_UVOV_CYC,
   parameter integer SS_DELAY_CYC = `RFP_SS_DELAY_CYC
) (
   input wire SYS_CLK,
   input wire RST_N,
   input wire REGULATOR_ENABLE_PIN,
   input wire OC_OVER,
   input wire OC_SHORT,
   input wire UV_BELOW_SLEW,
   input wire OV_ABOVE_SLEW,
   input wire SEVERE_OV_HIGH,
   input wire SEVERE_OV_LOW,
   input wire HS_GATE_LOW,
   input wire LS_GATE_LOW,
   input wire OUT_NEAR_SETPOINT,
   input wire SOFT_DONE,
   input wire SW_CYCLE,
   input wire PWM_HS_REQ,
   input wire PWM_LS_REQ,
   input wire [3:0] REG_ADDR,
   input wire [7:0] REG_WDATA,
   input wire REG_WR,
   input wire REG_RD,
   output reg [7:0] REG_RDATA,
   output wire IRQ,
   output reg HIGH_SIDE_DRIVE,
   output reg LOW_SIDE_DRIVE,
   output wire POWER_GOOD_OUTPUT_O,
   output wire POWER_GOOD_OUTPUT_OE,
   output reg STARTUP_SLEW_SEL,
   output reg DYNAMIC_SLEW_CURRENT_SEL,
   output reg SLEW_CHARGE_ENABLE
);
   localparam [4:0] ST_OFF = 5'h01;
   localparam [4:0] ST_DELAY = 5'h02;
   localparam [4:0] ST_SOFT = 5'h04;
   localparam [4:0] ST_PGWAIT = 5'h08;
   localparam [4:0] ST_RUN = 5'h10;
   localparam integer SHORT_CYC = `RFP_SHORT_CYC;
   localparam integer NSYNC = 12;

   // Three-stage synchronisers for every comparator and pin
   // A level counts only once stages two and three agree, so a one-cycle glitch is dropped
   wire [NSYNC-1:0] raw_in;
   reg [NSYNC-1:0] s1_q;
   reg [NSYNC-1:0] s2_q;
   reg [NSYNC-1:0] s3_q;
   reg [NSYNC-1:0] flt_q;
   assign raw_in = {SW_CYCLE, SOFT_DONE, OUT_NEAR_SETPOINT, LS_GATE_LOW, HS_GATE_LOW,
                    SEVERE_OV_LOW, SEVERE_OV_HIGH, OV_ABOVE_SLEW, UV_BELOW_SLEW,
                    OC_SHORT, OC_OVER, REGULATOR_ENABLE_PIN};
   always @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         s1_q <= {NSYNC{1'b0}};
         s2_q <= {NSYNC{1'b0}};
         s3_q <= {NSYNC{1'b0}};
         flt_q <= {NSYNC{1'b0}};
      end else begin
         s1_q <= raw_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         flt_q <= (s2_q & s3_q) | (flt_q & (s2_q | s3_q));
      end
   end
   wire en_s = flt_q[0];
   wire oc_s = flt_q[1];
   wire short_s = flt_q[2];
   wire uv_s = flt_q[3];
   wire ov_s = flt_q[4];
   wire sov_hi_s = flt_q[5];
   wire sov_lo_s = flt_q[6];
   wire hs_low_s = flt_q[7];
   wire ls_low_s = flt_q[8];
   wire near_s = flt_q[9];
   wire soft_done_s = flt_q[10];
   wire sw_s = flt_q[11];

   // Enable falling clears the latches; RST_N models the supply reset
   reg en_d1_q;
   wire en_fall = en_d1_q & ~en_s;
   always @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         en_d1_q <= 1'b0;
      end else begin
         en_d1_q <= en_s;
      end
   end

   // Overcurrent sampling timer and up/down counter
   // The timer runs free, so the sample grid never depends on when the comparator moves
   // The counter freezes once the fault latches; only an enable cycle or the supply reset empties it
   reg [15:0] oc_tmr_q;
   reg [3:0] oc_cnt_q;
   reg oc_flt_q;
   wire oc_tick = (oc_tmr_q == OC_SAMPLE_CYC - 1);
   // Eighth net over-sample: the counter stands one below the trip count at this tick
   wire oc_trip = oc_tick && oc_s && (oc_cnt_q == `RFP_OC_TRIP_COUNT - 1); // RULE2
   always @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         oc_tmr_q <= 16'h0000;
         oc_cnt_q <= 4'h0;
      end else begin
         oc_tmr_q <= oc_tick ? 16'h0000 : oc_tmr_q + 16'h0001; // RULE1
         if (en_fall || !en_s) begin
            oc_cnt_q <= 4'h0; // RULE17
         end else if (oc_tick && !oc_flt_q) begin
            if (oc_s) begin
               oc_cnt_q <= oc_cnt_q + 4'h1; // RULE1
            end else if (oc_cnt_q != 4'h0) begin
               oc_cnt_q <= oc_cnt_q - 4'h1; // RULE17
            end
         end
      end
   end

   // Persistence timers: a hard short is qualified well under 2 us, UV/OV over 1 ms.
   // The comparators already reference the live slew node, ramping or not.
   // Timers hold at their limit, so a long fault cannot wrap and re-arm
   reg [7:0] sh_tmr_q;
   reg [20:0] uv_tmr_q;
   reg [20:0] ov_tmr_q;
   reg uv_flt_q;
   reg ov_flt_q;
   wire short_hit = short_s && (sh_tmr_q == SHORT_CYC / 4);
   wire uv_hit = uv_s && (uv_tmr_q == UVOV_CYC); // RULE6
   wire ov_hit = ov_s && (ov_tmr_q == UVOV_CYC); // RULE6
   always @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         sh_tmr_q <= 8'h00;
         uv_tmr_q <= 21'h000000;
         ov_tmr_q <= 21'h000000;
      end else begin
         sh_tmr_q <= short_s ? (short_hit ? sh_tmr_q : sh_tmr_q + 8'h01) : 8'h00; // RULE3
         uv_tmr_q <= uv_s ? (uv_hit ? uv_tmr_q : uv_tmr_q + 21'h000001) : 21'h000000; // RULE4
         ov_tmr_q <= ov_s ? (ov_hit ? ov_tmr_q : ov_tmr_q + 21'h000001) : 21'h000000; // RULE5
      end
   end

   // Fault latches; enable low or the supply reset releases OC/UV/OV, only the supply reset releases sov_q
   reg sov_q;
   reg sov_ls_q;
   wire any_flt = oc_flt_q | uv_flt_q | ov_flt_q;
   always @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         oc_flt_q <= 1'b0;
         uv_flt_q <= 1'b0;
         ov_flt_q <= 1'b0;
         sov_q <= 1'b0;
         sov_ls_q <= 1'b0;
      end else begin
         if (!en_s) begin
            oc_flt_q <= 1'b0; // RULE8
            uv_flt_q <= 1'b0;
            ov_flt_q <= 1'b0;
         end else begin
            if (oc_trip || short_hit) begin
               oc_flt_q <= 1'b1; // RULE2 RULE3
            end
            if (uv_hit) begin
               uv_flt_q <= 1'b1; // RULE4
            end
            if (ov_hit) begin
               ov_flt_q <= 1'b1; // RULE5
            end
         end
         // Severe overvoltage ignores enable and other faults
         if (sov_hi_s) begin
            sov_q <= 1'b1; // RULE9 RULE11
         end
         if (sov_hi_s) begin
            sov_ls_q <= 1'b1; // RULE10
         end else if (sov_lo_s) begin
            sov_ls_q <= 1'b0; // RULE10
         end
      end
   end

   // Startup sequencer
   // Enable low or any fault drops the sequencer straight to off from any state
   reg [4:0] st_q;
   reg [4:0] st_d;
   reg [15:0] dly_q;
   reg [3:0] pg_cnt_q;
   reg sw_d1_q;
   wire sw_edge = sw_s & ~sw_d1_q;
   always @* begin
      st_d = st_q;
      case (st_q)
         ST_OFF: if (en_s && !any_flt && !sov_q) st_d = ST_DELAY;
         ST_DELAY: if (dly_q == SS_DELAY_CYC - 1) st_d = ST_SOFT; // RULE15
         ST_SOFT: if (near_s) st_d = ST_PGWAIT;
         ST_PGWAIT: if (sw_edge && pg_cnt_q == `RFP_PG_SW_CYCLES - 1) st_d = ST_RUN; // RULE16
         ST_RUN: st_d = ST_RUN;
         default: st_d = ST_OFF;
      endcase
      if (!en_s || any_flt || sov_q) begin
         st_d = ST_OFF;
      end
   end
   always @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_q <= ST_OFF;
         dly_q <= 16'h0000;
         pg_cnt_q <= 4'h0;
         sw_d1_q <= 1'b0;
      end else begin
         st_q <= st_d;
         sw_d1_q <= sw_s;
         dly_q <= (st_q == ST_DELAY) ? dly_q + 16'h0001 : 16'h0000;
         if (st_q != ST_PGWAIT) begin
            pg_cnt_q <= 4'h0;
         end else if (sw_edge) begin
            pg_cnt_q <= pg_cnt_q + 4'h1; // RULE16
         end
      end
   end

   // Slew source selection; the dynamic source stays on only once soft-start is complete
   wire running = (st_q == ST_SOFT) | (st_q == ST_PGWAIT) | (st_q == ST_RUN);
   wire soft_phase = running & ~soft_done_s;
   always @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         STARTUP_SLEW_SEL <= 1'b0;
         DYNAMIC_SLEW_CURRENT_SEL <= 1'b0;
         SLEW_CHARGE_ENABLE <= 1'b0;
      end else begin
         STARTUP_SLEW_SEL <= soft_phase; // RULE13
         DYNAMIC_SLEW_CURRENT_SEL <= running & soft_done_s; // RULE14
         SLEW_CHARGE_ENABLE <= running;
      end
   end

   // Gate drives with interlock; a fault or severe OV overrides the modulator
   // The gate-low inputs pass the synchronisers, adding dead time beyond the stage's own
   // Both requests at once are refused, so neither side is ever chosen by priority
   always @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         HIGH_SIDE_DRIVE <= 1'b0;
         LOW_SIDE_DRIVE <= 1'b0;
      end else begin
         if (sov_q) begin
            HIGH_SIDE_DRIVE <= 1'b0; // RULE9
            LOW_SIDE_DRIVE <= sov_ls_q & hs_low_s; // RULE10 RULE12
         end else if (any_flt || !running) begin
            HIGH_SIDE_DRIVE <= 1'b0; // RULE7
            LOW_SIDE_DRIVE <= 1'b0; // RULE7
         end else begin
            HIGH_SIDE_DRIVE <= PWM_HS_REQ & ~PWM_LS_REQ & ls_low_s & ~LOW_SIDE_DRIVE; // RULE12
            LOW_SIDE_DRIVE <= PWM_LS_REQ & ~PWM_HS_REQ & hs_low_s & ~HIGH_SIDE_DRIVE; // RULE12
         end
      end
   end

   // Open-drain power good: driven low unless released after startup
   reg pg_rel_q;
   wire pg_rel_d = (st_q == ST_RUN) & ~any_flt & ~sov_q; // RULE7 RULE9 RULE16
   always @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         pg_rel_q <= 1'b0;
      end else begin
         pg_rel_q <= pg_rel_d;
      end
   end
   assign POWER_GOOD_OUTPUT_O = 1'b0;
   assign POWER_GOOD_OUTPUT_OE = ~pg_rel_q;

   // Sticky event status, set wins over write-one-to-clear
   // Power good release and the counter trip are one-cycle events, not levels
   wire [`RFP_EVT_W-1:0] evt = {pg_rel_d & ~pg_rel_q, sov_hi_s & ~sov_q, ov_hit, uv_hit,
                                short_hit, oc_trip};
   reg [`RFP_EVT_W-1:0] sts_q;
   reg [`RFP_EVT_W-1:0] msk_q;
   reg ctrl_q;
   // Write decode shared by every writable register; unmapped writes fall through
   function wr_hit;
      input wr;
      input [3:0] addr;
      input [3:0] target;
      begin
         wr_hit = wr && (addr == target);
      end
   endfunction
   wire wr_sts = wr_hit(REG_WR, REG_ADDR, `RFP_ADDR_STATUS);
   wire wr_msk = wr_hit(REG_WR, REG_ADDR, `RFP_ADDR_MASK);
   wire wr_ctl = wr_hit(REG_WR, REG_ADDR, `RFP_ADDR_CTRL);
   always @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         sts_q <= {`RFP_EVT_W{1'b0}};
         msk_q <= `RFP_MASK_RST;
         ctrl_q <= `RFP_CTRL_RST;
         REG_RDATA <= 8'h00;
      end else begin
         sts_q <= (sts_q & ~(wr_sts ? REG_WDATA[`RFP_EVT_W-1:0] : {`RFP_EVT_W{1'b0}})) | evt;
         if (wr_msk) begin
            msk_q <= REG_WDATA[`RFP_EVT_W-1:0];
         end
         if (wr_ctl) begin
            ctrl_q <= REG_WDATA[0];
         end
         // Read data stand for one cycle only; idle cycles and unmapped reads give zero
         REG_RDATA <= 8'h00;
         if (REG_RD) begin
            case (REG_ADDR)
               `RFP_ADDR_STATUS: REG_RDATA <= {2'h0, sts_q};
               `RFP_ADDR_MASK: REG_RDATA <= {2'h0, msk_q};
               `RFP_ADDR_STATE: REG_RDATA <= {oc_cnt_q[2:0], sov_q, ov_flt_q, uv_flt_q,
                                              oc_flt_q, pg_rel_q};
               `RFP_ADDR_CTRL: REG_RDATA <= {7'h00, ctrl_q};
               default: REG_RDATA <= 8'h00;
            endcase
         end
      end
   end

   // Control bit 0 gates the interrupt line globally
   assign IRQ = ctrl_q & |(sts_q & msk_q);
endmodule
`default_nettype wire
